// *** logic/decode_if.sv ***
// Purpose: Carries decoded fields from the decoder to the execute top
// Assumes: Single clock domain
// Notes:   Pure combinational bundle
`timescale 1ns/1ns
interface decode_if;
  logic                         inc_hit;
  logic                         dec_hit;
  logic                         dest_sel;
  logic [incdec_pkg::ADDR_W-1:0] reg_addr;
  modport decoder (output inc_hit, output dec_hit, output dest_sel, output reg_addr);
  modport exec    (input inc_hit, input dec_hit, input dest_sel, input reg_addr);
endinterface

// *** logic/incdec_decoder.sv ***
// Purpose: Recognises the two instruction patterns and splits out operands
// Assumes: Instruction word is already valid in the execute stage
// Notes:   Other opcodes give no hit and are left to the rest of the core
`timescale 1ns/1ns
module incdec_decoder
(
  // Instruction
  input  wire logic [incdec_pkg::INSN_W-1:0] insn_in,
  input  wire logic                          valid_in,
  // Decoded fields
  decode_if.decoder                          dec
);
  wire logic [incdec_pkg::OPC_W-1:0] opc_field;
  assign opc_field = insn_in[incdec_pkg::INSN_W-1:incdec_pkg::OPC_LSB];
  assign dec.inc_hit  = valid_in && (opc_field == incdec_pkg::OPC_INC);
  assign dec.dec_hit  = valid_in && (opc_field == incdec_pkg::OPC_DEC_SKIP);
  assign dec.dest_sel = insn_in[incdec_pkg::DEST_BIT];
  assign dec.reg_addr = insn_in[incdec_pkg::ADDR_W-1:0];
endmodule

// *** logic/incdec_exec.sv ***
// Purpose: Execute stage for register increment and decrement-skip-if-zero
// Assumes: Register file reads combinationally at reg_addr_out
// Notes:   Results and write strobes are registered, one cycle after the word
`timescale 1ns/1ns
// Overview of operation
// - Increment reads the addressed register and yields its value plus one.
// - Destination bit 0 writes the accumulator, bit 1 writes back the source register.
// - Increment wraps modulo 256 and sets the zero flag on a zero result, else clears it.
// - The operand is a seven-bit register address plus one destination-select bit.
// - Decrement-and-skip subtracts one and skips the next word when the result is zero.
// - On a skip the prefetched word is discarded and a no-operation runs in its place.
module incdec_exec
(
  // Clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          srst_in,
  // Instruction from fetch
  input  wire logic [incdec_pkg::INSN_W-1:0] insn_in,
  input  wire logic                          insn_valid_in,
  // Register file read port
  output wire logic [incdec_pkg::ADDR_W-1:0] reg_addr_out,
  input  wire logic [incdec_pkg::DATA_W-1:0] reg_data_in,
  // Result
  output logic      [incdec_pkg::DATA_W-1:0] result_out,
  output logic      [incdec_pkg::ADDR_W-1:0] wr_addr_out,
  output logic                               reg_we_out,
  output logic                               acc_we_out,
  output logic                               zero_we_out,
  output logic                               zero_flag_out,
  // Pipeline control
  output logic                               skip_out,
  output wire logic                          squash_out
);
  decode_if dec ();

  incdec_decoder u_decoder
  (
    .insn_in  (insn_in),
    .valid_in (insn_valid_in),
    .dec      (dec)
  );

  // While a skip is pending the current word is the discarded prefetch
  logic                                squash;
  wire  logic                          live_inc;
  wire  logic                          live_dec;
  wire  logic                          dest_is_reg;
  wire  logic                          dest_is_acc;
  wire  logic [incdec_pkg::DATA_W-1:0] inc_sum;
  wire  logic [incdec_pkg::DATA_W-1:0] dec_diff;
  wire  logic [incdec_pkg::DATA_W-1:0] next_result;
  wire  logic                          next_zero;
  wire  logic                          next_write;
  wire  logic                          next_skip;
  // Reference copies of flag and skip, rebuilt from the operand for the checks
  logic                                ref_zero;
  logic                                ref_skip;

  assign squash_out   = squash;
  assign live_inc     = dec.inc_hit && !squash;
  assign live_dec     = dec.dec_hit && !squash;
  assign dest_is_reg  = (dec.dest_sel == incdec_pkg::DEST_REG);
  assign dest_is_acc  = (dec.dest_sel == incdec_pkg::DEST_ACC);
  assign reg_addr_out = dec.reg_addr;
  // Width-limited add wraps 0xFF to 0x00
  assign inc_sum      = reg_data_in + incdec_pkg::DATA_ONE;
  // Same width on the way down, so 0x00 becomes 0xFF and does not skip
  assign dec_diff     = reg_data_in - incdec_pkg::DATA_ONE;
  assign next_result  = live_inc ? inc_sum : dec_diff;
  assign next_zero    = (next_result == incdec_pkg::DATA_ZERO);
  assign next_write   = live_inc || live_dec;
  // Skip and squash share one condition so they can never disagree
  assign next_skip    = live_dec && next_zero;

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      result_out  <= incdec_pkg::DATA_ZERO;
      wr_addr_out <= '0;
      reg_we_out  <= 1'b0;
      acc_we_out  <= 1'b0;
    end
    else
    begin
      result_out  <= next_result;
      wr_addr_out <= dec.reg_addr;
      reg_we_out  <= next_write && dest_is_reg;
      acc_we_out  <= next_write && dest_is_acc;
    end
  end

  // Only increment touches the zero flag; decrement-skip leaves it alone
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      zero_we_out   <= 1'b0;
      zero_flag_out <= 1'b0;
    end
    else
    begin
      zero_we_out   <= live_inc;
      zero_flag_out <= live_inc ? next_zero : zero_flag_out;
    end
  end

  // Skip costs one extra cycle: the next word is replaced by a no-operation
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      skip_out <= 1'b0;
      squash   <= 1'b0;
    end
    else
    begin
      skip_out <= next_skip;
      squash   <= next_skip;
    end
  end

  // Check-only references, built from the raw operand rather than next_result
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      ref_zero <= 1'b0;
      ref_skip <= 1'b0;
    end
    else
    begin
      ref_zero <= live_inc ? (reg_data_in == ~incdec_pkg::DATA_ZERO) : ref_zero;
      ref_skip <= live_dec && (reg_data_in == incdec_pkg::DATA_ONE);
    end
  end

  AST_INC_WRAP: assert property (@(posedge clock_in) disable iff (srst_in)
    live_inc && reg_data_in == 8'hFF |=> result_out == 8'h00 && zero_flag_out)
    else $error("increment of FF did not wrap to zero with flag set");
  AST_INC_SUM: assert property (@(posedge clock_in) disable iff (srst_in)
    live_inc |=> result_out == $past(reg_data_in) + 8'h01)
    else $error("increment result wrong");
  AST_DEST_ACC: assert property (@(posedge clock_in) disable iff (srst_in)
    (live_inc || live_dec) && !dec.dest_sel |=> acc_we_out && !reg_we_out)
    else $error("destination 0 did not write accumulator");
  AST_DEST_REG: assert property (@(posedge clock_in) disable iff (srst_in)
    (live_inc || live_dec) && dec.dest_sel |=> reg_we_out && !acc_we_out
      && wr_addr_out == $past(dec.reg_addr))
    else $error("destination 1 did not write source register");
  AST_ADDR: assert property (@(posedge clock_in) disable iff (srst_in)
    (live_inc || live_dec) |=> wr_addr_out == $past(insn_in[incdec_pkg::ADDR_W-1:0]))
    else $error("write address not taken from low seven bits of the word");
  AST_DEC_SKIP: assert property (@(posedge clock_in) disable iff (srst_in)
    live_dec |=> skip_out == ($past(reg_data_in) == 8'h01))
    else $error("skip not tied to zero decrement result");
  AST_SQUASH: assert property (@(posedge clock_in) disable iff (srst_in)
    skip_out |-> squash_out ##1 !squash_out && !reg_we_out && !acc_we_out)
    else $error("prefetched word not discarded for exactly one cycle");
  AST_INC_ONE_CYCLE: assert property (@(posedge clock_in) disable iff (srst_in)
    live_inc |=> zero_we_out && !skip_out && (reg_we_out || acc_we_out))
    else $error("increment did not complete in one cycle");

  // Increment clears the flag on a non-zero sum; nothing else moves it
  AST_INC_CLEAR: assert property (@(posedge clock_in) disable iff (srst_in)
    live_inc && reg_data_in != 8'hFF |=> !zero_flag_out)
    else $error("increment left zero flag set on a non-zero result");
  AST_FLAG_HOLD: assert property (@(posedge clock_in) disable iff (srst_in)
    !live_inc |=> !zero_we_out && $stable(zero_flag_out))
    else $error("zero flag moved without an increment");
  AST_FLAG_REF: assert property (@(posedge clock_in) disable iff (srst_in)
    zero_flag_out == ref_zero)
    else $error("zero flag differs from the operand-based reference");

  // Exactly one destination per executed word
  AST_ONE_DEST: assert property (@(posedge clock_in) disable iff (srst_in)
    !(reg_we_out && acc_we_out))
    else $error("result written to both destinations");
  AST_DEST_DEC: assert property (@(posedge clock_in) disable iff (srst_in)
    live_dec |=> reg_we_out == $past(dec.dest_sel) && acc_we_out == !$past(dec.dest_sel))
    else $error("decrement-skip result sent to the wrong destination");

  // Decrement-and-skip
  AST_DEC_DIFF: assert property (@(posedge clock_in) disable iff (srst_in)
    live_dec |=> result_out == $past(reg_data_in) - 8'h01)
    else $error("decrement result wrong");
  AST_DEC_WRAP: assert property (@(posedge clock_in) disable iff (srst_in)
    live_dec && reg_data_in == 8'h00 |=> result_out == 8'hFF && !skip_out)
    else $error("decrement of zero must give FF and no skip");
  AST_NO_SKIP: assert property (@(posedge clock_in) disable iff (srst_in)
    live_dec && reg_data_in != 8'h01 |=> !skip_out && !squash_out)
    else $error("skip raised on a non-zero decrement result");
  AST_SKIP_SOURCE: assert property (@(posedge clock_in) disable iff (srst_in)
    skip_out |-> $past(live_dec) && result_out == 8'h00)
    else $error("skip raised without a zero decrement");
  AST_SKIP_REF: assert property (@(posedge clock_in) disable iff (srst_in)
    skip_out == ref_skip)
    else $error("skip differs from the operand-based reference");
  AST_DEC_FLAG: assert property (@(posedge clock_in) disable iff (srst_in)
    live_dec |=> !zero_we_out)
    else $error("decrement-skip touched the zero flag");

  // Discarded prefetch: one cycle, and none of its strobes, skip or flag updates reach an output
  AST_SQUASH_ONE: assert property (@(posedge clock_in) disable iff (srst_in)
    squash_out |=> !squash_out)
    else $error("squash held for more than one cycle");
  AST_SQUASH_QUIET: assert property (@(posedge clock_in) disable iff (srst_in)
    squash_out |=> !reg_we_out && !acc_we_out && !zero_we_out && !skip_out)
    else $error("discarded word produced a visible effect");
  AST_SQUASH_FLAG: assert property (@(posedge clock_in) disable iff (srst_in)
    squash_out |=> $stable(zero_flag_out))
    else $error("discarded increment changed the zero flag");

  // Decode seen from the word itself, through to the strobes
  AST_INC_DECODE: assert property (@(posedge clock_in) disable iff (srst_in)
    insn_valid_in && !squash_out
      && insn_in[incdec_pkg::INSN_W-1:incdec_pkg::OPC_LSB] == incdec_pkg::OPC_INC
      |=> zero_we_out)
    else $error("valid increment word was not executed");
  AST_DEC_DECODE: assert property (@(posedge clock_in) disable iff (srst_in)
    insn_valid_in && !squash_out
      && insn_in[incdec_pkg::INSN_W-1:incdec_pkg::OPC_LSB] == incdec_pkg::OPC_DEC_SKIP
      |=> reg_we_out || acc_we_out)
    else $error("valid decrement-skip word was not executed");
  AST_IDLE_QUIET: assert property (@(posedge clock_in) disable iff (srst_in)
    !(live_inc || live_dec) |=> !reg_we_out && !acc_we_out && !zero_we_out && !skip_out)
    else $error("strobe raised without an executed word");

  // Checked through reset, so it carries no disable
  AST_RESET_QUIET: assert property (@(posedge clock_in)
    srst_in |=> !reg_we_out && !acc_we_out && !zero_we_out && !skip_out && !squash_out)
    else $error("write strobe or skip left active by reset");
endmodule

// *** logic/incdec_pkg.sv ***
// Purpose: Shared constants for the increment / decrement-skip execute block
// Assumes: 14-bit instruction words, 8-bit data path
// Notes:   Opcode prefixes sit in the top six bits of the instruction word
package incdec_pkg;
  localparam int          INSN_W       = 14;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          OPC_W        = 6;
  localparam int          OPC_LSB      = 8;
  localparam int          DEST_BIT     = 7;
  localparam logic [5:0]  OPC_INC      = 6'h0A;
  localparam logic [5:0]  OPC_DEC_SKIP = 6'h0B;
  localparam logic [7:0]  DATA_ONE     = 8'h01;
  localparam logic [7:0]  DATA_ZERO    = 8'h00;
  localparam logic        DEST_ACC     = 1'b0;
  localparam logic        DEST_REG     = 1'b1;
  localparam logic [13:0] NOP_WORD     = 14'h0000;
endpackage

// *** tb/regfile_model.sv ***
// Purpose: Data-memory register file seen by the execute block
// Assumes: Read is combinational, write-back lands on the rising edge
// Notes:   Contents start unknown; the bench preloads each operand
`timescale 1ns/1ns
module regfile_model
(
  // Ports
  input  wire logic       clock_in,
  input  wire logic [6:0] rd_addr_in,
  output wire logic [7:0] rd_data_out,
  input  wire logic       we_in,
  input  wire logic [6:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in
);
  logic [7:0] mem [128];
  assign rd_data_out = mem[rd_addr_in];
  always @(posedge clock_in)
    if (we_in)
      mem[wr_addr_in] <= wr_data_in;
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the increment / decrement-skip block
// Assumes: Inputs change on the falling edge, results read at the next falling edge
// Notes:   Operands are biased towards 00 and 01 to hit the decrement wrap and skip cases
`timescale 1ns/1ns
module testbench;
  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [13:0] insn_in = 14'h0000;
  logic        insn_valid_in = 1'b0;
  logic [6:0]  reg_addr, wr_addr;
  logic [7:0]  reg_data, result;
  logic        reg_we, acc_we, zero_we, zero_flag, skip, squash;
  logic        sq = 1'b0;
  logic        zf = 1'b0;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #5 clock_in = ~clock_in;
  incdec_exec u_dut (.clock_in(clock_in), .srst_in(srst_in), .insn_in(insn_in),
    .insn_valid_in(insn_valid_in), .reg_addr_out(reg_addr), .reg_data_in(reg_data),
    .result_out(result), .wr_addr_out(wr_addr), .reg_we_out(reg_we), .acc_we_out(acc_we),
    .zero_we_out(zero_we), .zero_flag_out(zero_flag), .skip_out(skip), .squash_out(squash));
  regfile_model u_rf (.clock_in(clock_in), .rd_addr_in(reg_addr), .rd_data_out(reg_data),
    .we_in(reg_we), .wr_addr_in(wr_addr), .wr_data_in(result));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Result of an executed word, wrapping at eight bits both ways
  function automatic logic [7:0] expected_value(input logic inc, input logic [7:0] v);
    return inc ? v + 8'h01 : v - 8'h01;
  endfunction
  task automatic op(input logic [5:0] opc, input logic d, input logic [6:0] a,
                    input logic [7:0] v, input logic ok);
    logic       inc, hit, sk;
    logic [7:0] r;
    inc = (opc == incdec_pkg::OPC_INC);
    hit = ok && !sq && (inc || opc == incdec_pkg::OPC_DEC_SKIP);
    r = expected_value(inc, v);
    sk = hit && !inc && r == 8'h00;
    u_rf.mem[a] = v;
    insn_in = {opc, d, a};
    insn_valid_in = ok;
    #1 check({1'b0, reg_addr}, {1'b0, a});
    @(negedge clock_in);
    if (hit && inc)
      zf = (r == 8'h00);
    check({reg_we, acc_we, zero_we, skip, squash, 3'h0},
          {hit && d, hit && !d, hit && inc, sk, sk, 3'h0});
    if (hit)
      check(result, r);
    if (hit && d)
      check({1'b0, wr_addr}, {1'b0, a});
    check({7'h00, zero_flag}, {7'h00, zf});
    sq = sk;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      results;
    end
  end
  initial
  begin
    logic [31:0] rn;
    rn = $urandom(65);
    repeat (16) @(negedge clock_in);
    srst_in = 1'b0;
    op(6'h0A, 1'b1, 7'h05, 8'hFF, 1'b1);
    op(6'h0B, 1'b0, 7'h03, 8'h01, 1'b1);
    op(6'h0A, 1'b1, 7'h09, 8'h7F, 1'b1);
    op(6'h0B, 1'b1, 7'h7F, 8'h00, 1'b1);
    op(6'h0A, 1'b0, 7'h7F, 8'hFF, 1'b0);
    op(6'h0F, 1'b1, 7'h02, 8'h33, 1'b1);
    repeat (600)
    begin
      rn = $urandom;
      op(rn[3:0] == 4'h0 ? rn[9:4] : {5'h05, rn[4]}, rn[5], rn[22:16],
         rn[11:10] == 2'h0 ? {7'h00, rn[12]} : rn[31:24], rn[15:13] != 3'h0);
    end
    // Mid-run reset after a flag-setting increment: all must come back quiet
    op(6'h0A, 1'b0, 7'h11, 8'hFF, 1'b1);
    srst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    check({reg_we, acc_we, zero_we, zero_flag, skip, squash, 2'h0}, 8'h00);
    check(result, 8'h00);
    srst_in = 1'b0;
    zf = 1'b0;
    sq = 1'b0;
    op(6'h0B, 1'b1, 7'h11, 8'h01, 1'b1);
    op(6'h0A, 1'b1, 7'h12, 8'h00, 1'b1);
    results;
  end
endmodule
